// file: inc/mpmc_pkg.sv
// Constants, types and helpers of the magnetometer power mode control
package mpmc_pkg;
    // Clock rate and derived cycles per microsecond
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned US_CYC = CLK_HZ / 1_000_000;

    // Register offsets
    localparam logic [7:0] ADDR_ID = 8'h40;
    localparam logic [7:0] ADDR_PWR = 8'h4b;
    localparam logic [7:0] ADDR_OPC = 8'h4c;
    localparam logic [7:0] ADDR_XYREP = 8'h51;
    localparam logic [7:0] ADDR_ZREP = 8'h52;
    localparam logic [7:0] ADDR_TRIM = 8'h5d;

    // Identification value, arbitrary
    localparam logic [7:0] ID_VALUE = 8'h5a;

    // Field positions and writable masks
    localparam int unsigned PWR_ON_BIT = 0;
    localparam int unsigned PWR_3W_BIT = 2;
    localparam int unsigned PWR_SRST_BIT = 7;
    localparam logic [7:0] PWR_MASK = 8'h05;
    localparam int unsigned OPC_MODE_LSB = 1;
    localparam int unsigned OPC_ODR_LSB = 3;
    localparam logic [7:0] OPC_MASK = 8'h3e;

    // Operating state field codes
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] OPM_FORCED = 2'h1;
    localparam logic [1:0] OPM_SLEEP = 2'h3;

    // Reset values
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [7:0] OPC_RST = 8'h06;
    localparam logic [7:0] XYREP_RST = 8'h00;
    localparam logic [7:0] ZREP_RST = 8'h00;

    // Measurement and output rate timing
    localparam int unsigned XY_REPETITION_SETTING_US = 145;
    localparam int unsigned Z_REP_US = 500;
    localparam int unsigned OVH_US = 980;
    localparam int unsigned ODR_BASE_US = 100_000;
    localparam int unsigned XY_REPETITION_SETTING_CYC = XY_REPETITION_SETTING_US * US_CYC;
    localparam int unsigned Z_REP_CYC = Z_REP_US * US_CYC;
    localparam int unsigned OVH_CYC = OVH_US * US_CYC;
    localparam int unsigned ODR_BASE_CYC = ODR_BASE_US * US_CYC;

    // Trim storage address width
    localparam int unsigned TRIM_AW = 2;

    // Power states, one-hot
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_BOOT = 6'h02,
        ST_SUSP = 6'h04,
        ST_SLEEP = 6'h08,
        ST_NORM = 6'h10,
        ST_FORCE = 6'h20
    } mpmc_state_t;

    // Actual repetitions from a repetition setting
    function automatic logic [8:0] rep_count(input logic [7:0] s,
                                             input logic is_z);
        return is_z ? 9'(s) + 9'h001 : {s, 1'b1};
    endfunction
endpackage

// file: inc/mpmc_meas_if.sv
// Link between the power controller and the measurement timer
`timescale 1ns/1ns
interface mpmc_meas_if;
    logic start;
    logic abort;
    logic busy;
    logic done;
    logic [8:0] xy_repetition_count;
    logic [8:0] z_repetition_count;
    modport ctrl (output start, abort, xy_repetition_count,
                  z_repetition_count, input busy, done);
    modport tmr (input start, abort, xy_repetition_count,
                 z_repetition_count, output busy, done);
endinterface

// file: src/mpmc_meas_timer.sv
// Measurement phase timer: X/Y repetitions, Z repetitions, overhead
`timescale 1ns/1ns
module mpmc_meas_timer #(
    parameter int unsigned XY_CYC = mpmc_pkg::XY_REPETITION_SETTING_CYC,
    parameter int unsigned Z_CYC = mpmc_pkg::Z_REP_CYC,
    parameter int unsigned OVH_CYC = mpmc_pkg::OVH_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    mpmc_meas_if.tmr m
);
    import mpmc_pkg::*;

    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_XY = 4'h2,
        PH_Z = 4'h4,
        PH_OVH = 4'h8
    } mpmc_phase_t;

    localparam logic [31:0] XY_LD = 32'(XY_CYC - 1);
    localparam logic [31:0] Z_LD = 32'(Z_CYC - 1);
    localparam logic [31:0] OVH_LD = 32'(OVH_CYC - 1);

    mpmc_phase_t ph_q, ph_d;
    logic [31:0] cyc_q, cyc_d;
    logic [8:0] rep_q, rep_d;
    logic done_q, done_d;

    assign m.busy = (ph_q != PH_IDLE);
    assign m.done = done_q;

    // Phase sequencing; abort beats start, start restarts a busy run
    always_comb begin
        ph_d = ph_q;
        cyc_d = cyc_q;
        rep_d = rep_q;
        done_d = 1'b0;
        if (m.abort) begin
            ph_d = PH_IDLE;
        end else if (m.start) begin
            ph_d = PH_XY;
            cyc_d = XY_LD;
            rep_d = m.xy_repetition_count - 9'h001;
        end else begin
            unique case (ph_q)
                PH_IDLE: cyc_d = cyc_q;
                PH_XY: begin
                    if (cyc_q != 32'h0) begin
                        cyc_d = cyc_q - 32'h1;
                    end else if (rep_q != 9'h000) begin
                        rep_d = rep_q - 9'h001;
                        cyc_d = XY_LD;
                    end else begin
                        ph_d = PH_Z;
                        cyc_d = Z_LD;
                        rep_d = m.z_repetition_count - 9'h001;
                    end
                end
                PH_Z: begin
                    if (cyc_q != 32'h0) begin
                        cyc_d = cyc_q - 32'h1;
                    end else if (rep_q != 9'h000) begin
                        rep_d = rep_q - 9'h001;
                        cyc_d = Z_LD;
                    end else begin
                        ph_d = PH_OVH;
                        cyc_d = OVH_LD;
                    end
                end
                PH_OVH: begin
                    if (cyc_q != 32'h0) begin
                        cyc_d = cyc_q - 32'h1;
                    end else begin
                        ph_d = PH_IDLE;
                        done_d = 1'b1;
                    end
                end
            endcase
        end
    end

    // Phase registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_q <= PH_IDLE;
            cyc_q <= 32'h0;
            rep_q <= 9'h000;
            done_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            cyc_q <= cyc_d;
            rep_q <= rep_d;
            done_q <= done_d;
        end
    end

    // Elapsed time since start and expected length, for checking
    logic [31:0] el_q, exp_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            el_q <= 32'h0;
            exp_q <= 32'h0;
        end else if (m.start) begin
            el_q <= 32'h0;
            exp_q <= 32'(32'(m.xy_repetition_count) * XY_CYC
                     + 32'(m.z_repetition_count) * Z_CYC + OVH_CYC);
        end else begin
            el_q <= el_q + 32'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_done_time;
        m.done |-> el_q == exp_q;
    endproperty
    a_done_time: assert property (p_done_time)
        else $error("measurement length differs from repetitions");

    property p_abort_drop;
        m.abort |=> !m.busy && !m.done;
    endproperty
    a_abort_drop: assert property (p_abort_drop)
        else $error("aborted measurement still completes");

    property p_restart_drop;
        m.start && !m.abort && m.busy |=> m.busy && !m.done;
    endproperty
    a_restart_drop: assert property (p_restart_drop)
        else $error("interrupted measurement still completes");
endmodule

// file: src/mpmc_top.sv
// Magnetometer power mode and measurement sequencing controller
`timescale 1ns/1ns
module mpmc_top #(
    parameter int unsigned XY_CYC = mpmc_pkg::XY_REPETITION_SETTING_CYC,
    parameter int unsigned Z_CYC = mpmc_pkg::Z_REP_CYC,
    parameter int unsigned OVH_CYC = mpmc_pkg::OVH_CYC,
    parameter int unsigned ODR_CYC = mpmc_pkg::ODR_BASE_CYC,
    parameter int unsigned TRIM_AW = mpmc_pkg::TRIM_AW
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic vdd_ok,
    input wire logic vddio_ok,
    input wire logic spi_mode,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_oe,
    output logic trim_rd,
    output logic [TRIM_AW-1:0] trim_addr,
    input wire logic [7:0] trim_data,
    output mpmc_pkg::mpmc_state_t mode,
    output logic three_wire_serial_select,
    output logic meas_active,
    output logic result_commit
);
    import mpmc_pkg::*;

    localparam logic [TRIM_AW-1:0] TRIM_LAST = '1;
    localparam logic [8:0] TRIM_N = 9'(1 << TRIM_AW);

    mpmc_meas_if m ();

    mpmc_state_t st_q, st_d;
    logic [7:0] pwr_q, pwr_d;
    logic [7:0] opc_q, opc_d;
    logic [7:0] xyr_q, xyr_d;
    logic [7:0] zr_q, zr_d;
    logic [TRIM_AW-1:0] tidx_q, tidx_d;
    logic [31:0] odr_q, odr_d;
    logic [7:0] rd_q, rd_d;
    logic oe_q, oe_d;
    logic cm_q, cm_d;
    logic act_q;
    logic trd_q, trd_d;
    logic sh_we;
    logic [7:0] trim_q [1 << TRIM_AW];
    logic por_n, full_acc, user_acc;
    logic [7:0] toff;
    logic [1:0] wr_mode;

    // Output rate period from the rate field of the operation byte
    function automatic logic [31:0] odr_period(input logic [7:0] opc);
        return 32'(ODR_CYC >> opc[OPC_ODR_LSB +: 3]);
    endfunction

    // Logic reset: pin reset or either supply missing
    assign por_n = rst_n && vdd_ok && vddio_ok;
    assign full_acc = (st_q == ST_SLEEP) || (st_q == ST_NORM)
                   || (st_q == ST_FORCE);
    assign user_acc = full_acc || (st_q == ST_SUSP);
    assign toff = reg_addr - ADDR_TRIM;
    assign wr_mode = reg_wdata[OPC_MODE_LSB +: 2];

    // Actual repetition counts handed to the timer
    assign m.xy_repetition_count = rep_count(xyr_q, 1'b0);
    assign m.z_repetition_count = rep_count(zr_q, 1'b1);

    mpmc_meas_timer #(
        .XY_CYC(XY_CYC),
        .Z_CYC(Z_CYC),
        .OVH_CYC(OVH_CYC)
    ) u_timer (
        .clk(clk),
        .rst_n(por_n),
        .m(m)
    );

    // Next state of the power sequencer and its registers
    always_comb begin
        st_d = st_q;
        pwr_d = pwr_q;
        opc_d = opc_q;
        xyr_d = xyr_q;
        zr_d = zr_q;
        tidx_d = tidx_q;
        odr_d = odr_q;
        rd_d = rd_q;
        oe_d = 1'b0;
        cm_d = 1'b0;
        sh_we = 1'b0;
        m.start = 1'b0;
        m.abort = 1'b0;
        // Autonomous progress of each state
        unique case (st_q)
            ST_OFF: begin
                st_d = ST_BOOT;
                tidx_d = '0;
            end
            ST_BOOT: begin
                sh_we = 1'b1;
                if (tidx_q == TRIM_LAST) begin
                    st_d = ST_SUSP;
                end else begin
                    tidx_d = tidx_q + 1'b1;
                end
            end
            ST_SUSP, ST_SLEEP: begin
                odr_d = odr_q;
            end
            ST_NORM: begin
                cm_d = m.done;
                if (odr_q == 32'h0) begin
                    m.start = 1'b1;
                    odr_d = odr_period(opc_q) - 32'h1;
                end else begin
                    odr_d = odr_q - 32'h1;
                end
            end
            ST_FORCE: begin
                if (m.done) begin
                    cm_d = 1'b1;
                    opc_d[OPC_MODE_LSB +: 2] = OPM_SLEEP;
                    st_d = ST_SLEEP;
                end
            end
        endcase
        // Register writes; later assignments override the above
        if (reg_wr && user_acc && reg_addr == ADDR_PWR) begin
            pwr_d = reg_wdata & PWR_MASK;
            if (!reg_wdata[PWR_ON_BIT]) begin
                if (st_q != ST_SUSP) begin
                    st_d = ST_SUSP;
                    opc_d = OPC_RST;
                    xyr_d = XYREP_RST;
                    zr_d = ZREP_RST;
                    m.abort = 1'b1;
                end
            end else if (st_q == ST_SUSP) begin
                st_d = ST_SLEEP;
            end else if (reg_wdata[PWR_SRST_BIT]) begin
                st_d = ST_SLEEP;
                opc_d = OPC_RST;
                xyr_d = XYREP_RST;
                zr_d = ZREP_RST;
                m.abort = 1'b1;
            end
        end else if (reg_wr && full_acc && reg_addr == ADDR_OPC) begin
            opc_d = reg_wdata & OPC_MASK;
            unique case (wr_mode)
                OPM_SLEEP: begin
                    st_d = ST_SLEEP;
                    m.abort = 1'b1;
                end
                OPM_NORMAL: begin
                    if (st_q != ST_NORM) begin
                        st_d = ST_NORM;
                        m.start = 1'b1;
                        odr_d = odr_period(reg_wdata) - 32'h1;
                    end
                end
                OPM_FORCED: begin
                    st_d = ST_FORCE;
                    m.start = 1'b1;
                end
                default: begin
                    opc_d[OPC_MODE_LSB +: 2] = opc_q[OPC_MODE_LSB +: 2];
                end
            endcase
        end else if (reg_wr && full_acc && reg_addr == ADDR_XYREP) begin
            xyr_d = reg_wdata;
        end else if (reg_wr && full_acc && reg_addr == ADDR_ZREP) begin
            zr_d = reg_wdata;
        end
        // Register reads, answered one cycle later
        if (reg_rd) begin
            oe_d = 1'b1;
            rd_d = 8'h00;
            if (full_acc) begin
                if (reg_addr == ADDR_ID) begin
                    rd_d = ID_VALUE;
                end else if (reg_addr == ADDR_PWR) begin
                    rd_d = pwr_q;
                end else if (reg_addr == ADDR_OPC) begin
                    rd_d = opc_q;
                end else if (reg_addr == ADDR_XYREP) begin
                    rd_d = xyr_q;
                end else if (reg_addr == ADDR_ZREP) begin
                    rd_d = zr_q;
                end else if ({1'b0, toff} < TRIM_N) begin
                    rd_d = trim_q[toff[TRIM_AW-1:0]];
                end
            end else if (user_acc && reg_addr == ADDR_PWR) begin
                rd_d = pwr_q;
            end else begin
                oe_d = !spi_mode;
            end
        end
        trd_d = (st_d == ST_BOOT);
    end

    // Sequencer registers, all defaulted by power-on reset
    always_ff @(posedge clk) begin
        if (!por_n) begin
            st_q <= ST_OFF;
            pwr_q <= PWR_RST;
            opc_q <= OPC_RST;
            xyr_q <= XYREP_RST;
            zr_q <= ZREP_RST;
            tidx_q <= '0;
            odr_q <= 32'h0;
            rd_q <= 8'h00;
            oe_q <= 1'b0;
            cm_q <= 1'b0;
            act_q <= 1'b0;
            trd_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pwr_q <= pwr_d;
            opc_q <= opc_d;
            xyr_q <= xyr_d;
            zr_q <= zr_d;
            tidx_q <= tidx_d;
            odr_q <= odr_d;
            rd_q <= rd_d;
            oe_q <= oe_d;
            cm_q <= cm_d;
            act_q <= m.busy;
            trd_q <= trd_d;
        end
    end

    // Trim shadow copy during start-up
    always_ff @(posedge clk) begin
        if (sh_we) begin
            trim_q[tidx_q] <= trim_data;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = rd_q;
    assign reg_rdata_oe = oe_q;
    assign trim_rd = trd_q;
    assign trim_addr = tidx_q;
    assign mode = st_q;
    assign three_wire_serial_select = pwr_q[PWR_3W_BIT];
    assign meas_active = act_q;
    assign result_commit = cm_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!por_n);

    property p_off;
        @(posedge clk) disable iff (!rst_n)
        !(vdd_ok && vddio_ok) |=> st_q == ST_OFF;
    endproperty
    a_off: assert property (p_off)
        else $error("device left off state without both supplies");

    sequence s_boot;
        st_q == ST_BOOT [*4] ##1 st_q == ST_SUSP;
    endsequence
    property p_boot;
        st_q == ST_OFF |=> s_boot;
    endproperty
    a_boot: assert property (p_boot)
        else $error("start-up copy did not end in suspend");

    property p_defaults;
        st_q == ST_OFF |-> pwr_q == PWR_RST && opc_q == OPC_RST
                           && xyr_q == XYREP_RST && zr_q == ZREP_RST;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("registers not at defaults after reset");

    property p_susp_clear;
        st_q == ST_SUSP |-> opc_q == OPC_RST && xyr_q == XYREP_RST
                            && zr_q == ZREP_RST;
    endproperty
    a_susp_clear: assert property (p_susp_clear)
        else $error("register content kept or written in suspend");

    property p_susp_id;
        st_q == ST_SUSP && reg_rd && reg_addr == ADDR_ID
        |=> reg_rdata == 8'h00 && reg_rdata_oe == !$past(spi_mode);
    endproperty
    a_susp_id: assert property (p_susp_id)
        else $error("suspend identification read answered wrongly");

    property p_sleep_id;
        st_q == ST_SLEEP && reg_rd && reg_addr == ADDR_ID
        |=> reg_rdata == ID_VALUE && reg_rdata_oe;
    endproperty
    a_sleep_id: assert property (p_sleep_id)
        else $error("identification not readable in sleep");

    property p_pwr_on;
        st_q == ST_SUSP && reg_wr && reg_addr == ADDR_PWR
        && reg_wdata[PWR_ON_BIT] |=> st_q == ST_SLEEP;
    endproperty
    a_pwr_on: assert property (p_pwr_on)
        else $error("power bit did not wake to sleep");

    property p_pwr_off;
        (st_q == ST_SLEEP || st_q == ST_NORM) && reg_wr
        && reg_addr == ADDR_PWR && !reg_wdata[PWR_ON_BIT]
        |=> st_q == ST_SUSP ##1 !meas_active;
    endproperty
    a_pwr_off: assert property (p_pwr_off)
        else $error("power bit zero did not reach suspend");

    sequence s_forced_end;
        st_q == ST_SLEEP && result_commit
        && opc_q[OPC_MODE_LSB +: 2] == OPM_SLEEP;
    endsequence
    property p_force_end;
        st_q == ST_FORCE && m.done && !reg_wr |=> s_forced_end;
    endproperty
    a_force_end: assert property (p_force_end)
        else $error("forced measurement did not return to sleep");

    property p_norm_start;
        st_q == ST_SLEEP && reg_wr && reg_addr == ADDR_OPC
        && wr_mode == OPM_NORMAL |=> st_q == ST_NORM && m.busy;
    endproperty
    a_norm_start: assert property (p_norm_start)
        else $error("normal mode entry did not start a measurement");

    property p_norm_sleep;
        st_q == ST_NORM && reg_wr && reg_addr == ADDR_OPC
        && wr_mode == OPM_SLEEP |=> st_q == ST_SLEEP && !m.busy;
    endproperty
    a_norm_sleep: assert property (p_norm_sleep)
        else $error("sleep code did not leave normal mode");

    property p_norm_commit;
        st_q == ST_NORM && m.done |=> result_commit;
    endproperty
    a_norm_commit: assert property (p_norm_commit)
        else $error("normal measurement result not committed");
endmodule

// file: verif/mpmc_host.sv
// Host model that issues register accesses to the controller
`timescale 1ns/1ns
module mpmc_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // One access held for one cycle, then the bus is scrambled
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge clk);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a; // Stale address must not look valid
        reg_wdata = ~d;
    endtask
endmodule

// file: verif/tb.sv
// Self-checking bench of the power mode controller
`timescale 1ns/1ns
module tb;
    import mpmc_pkg::*;
    localparam int unsigned XC = 3;
    localparam int unsigned ZC = 5;
    localparam int unsigned OC = 7;
    localparam int unsigned PC = 200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vdd_ok = 1'b0;
    logic vddio_ok = 1'b0;
    logic spi_mode = 1'b0;
    logic reg_wr, reg_rd, reg_rdata_oe, trim_rd;
    logic three_wire_serial_select, meas_active, result_commit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, trim_data, xs, zs;
    logic [1:0] trim_addr;
    mpmc_state_t mode;
    logic [8:0] exp_q[$];
    logic taken = 1'b0;
    logic [31:0] seed = 32'h9c74759d;
    int miscompares = 0;
    int comparisons = 0;
    int n;

    always #5 clk = ~clk;

    // Trim storage: each word derived from its address
    assign trim_data = 8'hc0 + 8'(trim_addr);

    mpmc_top #(.XY_CYC(XC), .Z_CYC(ZC), .OVH_CYC(OC), .ODR_CYC(PC),
        .TRIM_AW(2)) u_dut (.clk(clk), .rst_n(rst_n), .vdd_ok(vdd_ok),
        .vddio_ok(vddio_ok), .spi_mode(spi_mode), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rdata_oe(reg_rdata_oe),
        .trim_rd(trim_rd), .trim_addr(trim_addr), .trim_data(trim_data),
        .mode(mode), .three_wire_serial_select(three_wire_serial_select),
        .meas_active(meas_active), .result_commit(result_commit));

    mpmc_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Measurement length from actual repetitions, not settings
    function automatic int tm(input int x, input int z);
        return (2 * x + 1) * XC + (z + 1) * ZC + OC;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        exp_q.push_back(e);
        u_host.acc(1'b0, a, 8'h00);
    endtask

    // Count from the falling edge before the call to a commit pulse;
    // the strobe leads the start edge by one, commit trails done by one
    task automatic wait_commit(output int k);
        k = 1;
        while (result_commit !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
    endtask

    // Record read strobes taken by the design
    always @(posedge clk) taken <= reg_rd;

    // Compare each read answer with the oldest note
    always @(negedge clk) begin
        if (taken) begin
            if (exp_q.size() == 0) begin
                chk("rdata_note", 32'h0, 32'h1);
            end else begin
                chk("rdata", exp_q.pop_front(), {reg_rdata_oe, reg_rdata});
            end
        end
    end

    // Watchdog well beyond the expected run of several hundred cycles
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        vdd_ok = 1'b1;
        repeat (5) @(negedge clk);
        chk("mode", ST_OFF, mode);
        vddio_ok = 1'b1;
        @(negedge clk);
        chk("mode", ST_BOOT, mode);
        chk("trim_rd", 1, trim_rd);
        chk("trim_addr", 0, trim_addr);
        repeat (4) @(negedge clk);
        chk("mode", ST_SUSP, mode);
        rd(ADDR_ID, 9'h100);
        spi_mode = 1'b1;
        rd(ADDR_ID, 9'h000);
        wr(ADDR_OPC, 8'h02);
        wr(ADDR_PWR, 8'h04);
        chk("three_wire", 1, three_wire_serial_select);
        rd(ADDR_PWR, 9'h104);
        wr(ADDR_PWR, 8'h05);
        chk("mode", ST_SLEEP, mode);
        rd(ADDR_OPC, 9'h106);
        rd(ADDR_ID, {1'b1, ID_VALUE});
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_TRIM + 8'(i), {1'b1, 8'hc0 + 8'(i)});
        end
        // Forced shots: preset 3/3 first, then random settings
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            xs = (i == 0) ? 8'h01 : {6'h00, seed[1:0]};
            zs = (i == 0) ? 8'h02 : {6'h00, seed[3:2]};
            wr(ADDR_XYREP, xs);
            wr(ADDR_ZREP, zs);
            rd(ADDR_ZREP, {1'b1, zs});
            wr(ADDR_OPC, 8'h02);
            chk("mode", ST_FORCE, mode);
            wait_commit(n);
            chk("force_len", tm(xs, zs) + 2, n);
            chk("mode", ST_SLEEP, mode);
            chk("meas_active", 0, meas_active);
            rd(ADDR_OPC, 9'h106);
        end
        // Early retrigger drops the first shot
        wr(ADDR_OPC, 8'h02);
        repeat (3) @(negedge clk);
        chk("meas_active", 1, meas_active);
        wr(ADDR_OPC, 8'h02);
        wait_commit(n);
        chk("retrig_len", tm(xs, zs) + 2, n);
        wr(ADDR_OPC, 8'h00);
        chk("mode", ST_NORM, mode);
        wait_commit(n);
        chk("norm_first", tm(xs, zs) + 2, n);
        @(negedge clk);
        wait_commit(n);
        chk("norm_period", PC, n);
        wr(ADDR_OPC, 8'h06);
        chk("mode", ST_SLEEP, mode);
        // Reserved state code keeps the old state and field
        wr(ADDR_OPC, 8'h0c);
        chk("mode", ST_SLEEP, mode);
        rd(ADDR_OPC, 9'h10e);
        wr(ADDR_OPC, 8'h00);
        wr(ADDR_PWR, 8'h85);
        chk("mode", ST_SLEEP, mode);
        rd(ADDR_XYREP, 9'h100);
        wr(ADDR_ZREP, 8'h03);
        wr(ADDR_PWR, 8'h04);
        chk("mode", ST_SUSP, mode);
        wr(ADDR_ZREP, 8'h07);
        wr(ADDR_PWR, 8'h05);
        rd(ADDR_ZREP, 9'h100);
        rd(ADDR_PWR, 9'h105);
        repeat (5) @(negedge clk);
        complete_run();
    end
endmodule
